// file: hw/rdm_pkg.sv
// package for the regulator discharge and mode-0 register bank
package rdm_pkg;
  localparam logic [7:0] DISCHARGE_OFFSET = 8'h21;
  localparam logic [7:0] MODE0_OFFSET = 8'h22;
  localparam logic [7:0] DISCHARGE_RESET = 8'h00;
  localparam int CORE_BUCK_BIT = 3;
  localparam int SYSTEM_BUCK_BIT = 2;
  localparam int AON_LDO_BIT = 1;
  localparam int SYSTEM_LDO_BIT = 0;
  localparam int SHIP_BIT = 7;
  localparam int PIN_SOURCE_BIT = 6;
  localparam logic [5:0] CORE_VOLT_RESET = 6'h14;
  localparam logic [5:0] CORE_VOLT_MAX_LINEAR = 6'h28;
  localparam logic [5:0] CORE_VOLT_FIXED = 6'h3f;
  localparam logic [11:0] CORE_VOLT_BASE_MV = 12'h1f4;
  localparam logic [11:0] CORE_VOLT_STEP_MV = 12'h019;
  localparam logic [11:0] CORE_VOLT_FIXED_MV = 12'h708;
  localparam logic [11:0] CORE_VOLT_SAT_MV = 12'h5dc;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rdm_req_t;

  typedef struct packed {
    logic core_buck;
    logic system_buck;
    logic aon_ldo;
    logic system_ldo;
  } rdm_reg4_t;
endpackage

// file: hw/rdm_regs.sv
// register bank for regulator discharge and mode-0 configuration
`timescale 1ns/1ps
`default_nettype none
module rdm_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register access port from the serial slave
  input wire rdm_pkg::rdm_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // nonvolatile defaults, sampled in reset
  input wire logic nv_pin_source_i,
  input wire logic [5:0] nv_core_volt_i,
  // regulator enables and mode pins
  input wire rdm_pkg::rdm_reg4_t reg_enable_i,
  input wire logic mode_select_pin_a_i,
  input wire logic mode_select_pin_b_i,
  input wire logic mode_reg_bit_a_i,
  input wire logic mode_reg_bit_b_i,
  // controls to the analog side
  output rdm_pkg::rdm_reg4_t bleed_on_o,
  output logic ship_mode_o,
  output logic [1:0] mode_sel_o,
  output logic [5:0] core_buck_code_o,
  output logic [11:0] core_buck_mv_o
);

  logic [7:0] discharge;
  logic ship_en;
  logic mode0_pin_mode_source;
  logic [5:0] mode0_core_buck_voltage;
  logic wr_disch;
  logic wr_mode0;

  // millivolt target for a code, shared by the reset and run paths
  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    logic [11:0] mv;
    mv = rdm_pkg::CORE_VOLT_SAT_MV;
    if (code == rdm_pkg::CORE_VOLT_FIXED)
      mv = rdm_pkg::CORE_VOLT_FIXED_MV;
    else if (code <= rdm_pkg::CORE_VOLT_MAX_LINEAR)
      mv = 12'(rdm_pkg::CORE_VOLT_BASE_MV + 12'(code) * rdm_pkg::CORE_VOLT_STEP_MV);
    return mv;
  endfunction

  assign wr_disch = req_i.write && (req_i.addr == rdm_pkg::DISCHARGE_OFFSET);
  assign wr_mode0 = req_i.write && (req_i.addr == rdm_pkg::MODE0_OFFSET);

  // reserved bits are kept only so software reads back what it wrote
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      discharge <= rdm_pkg::DISCHARGE_RESET;
    else if (wr_disch)
      discharge <= req_i.wdata;
  end

  // sync reset lets the nonvolatile straps be caught as data
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ship_en <= 1'b0;
      mode0_pin_mode_source <= nv_pin_source_i;
      mode0_core_buck_voltage <= nv_core_volt_i;
    end
    else if (wr_mode0)
    begin
      ship_en <= req_i.wdata[rdm_pkg::SHIP_BIT];
      mode0_pin_mode_source <= req_i.wdata[rdm_pkg::PIN_SOURCE_BIT];
      mode0_core_buck_voltage <= req_i.wdata[5:0];
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= req_i.read;
      if (req_i.read)
      begin
        unique case (req_i.addr)
          rdm_pkg::DISCHARGE_OFFSET: rdata_o <= discharge;
          rdm_pkg::MODE0_OFFSET:
            rdata_o <= {ship_en, mode0_pin_mode_source, mode0_core_buck_voltage};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // analog outputs registered to keep glitches off the regulators
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      bleed_on_o <= '0;
      ship_mode_o <= 1'b0;
      mode_sel_o <= 2'h0;
      core_buck_code_o <= rdm_pkg::CORE_VOLT_RESET;
      core_buck_mv_o <= code_to_mv(rdm_pkg::CORE_VOLT_RESET);
    end
    else
    begin
      bleed_on_o.core_buck <= !reg_enable_i.core_buck
        && !discharge[rdm_pkg::CORE_BUCK_BIT];
      bleed_on_o.system_buck <= !reg_enable_i.system_buck
        && !discharge[rdm_pkg::SYSTEM_BUCK_BIT];
      bleed_on_o.aon_ldo <= !reg_enable_i.aon_ldo
        && !discharge[rdm_pkg::AON_LDO_BIT];
      bleed_on_o.system_ldo <= !reg_enable_i.system_ldo
        && !discharge[rdm_pkg::SYSTEM_LDO_BIT];
      ship_mode_o <= ship_en;
      if (mode0_pin_mode_source)
        mode_sel_o <= {mode_select_pin_b_i, mode_select_pin_a_i};
      else
        mode_sel_o <= {mode_reg_bit_b_i, mode_reg_bit_a_i};
      core_buck_code_o <= mode0_core_buck_voltage;
      core_buck_mv_o <= code_to_mv(mode0_core_buck_voltage);
    end
  end

  // checks
  property p_disch_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_disch |=> discharge == $past(req_i.wdata);
  endproperty
  a_disch_write: assert property (p_disch_write) else $error("discharge write lost");

  property p_read_mode0;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (req_i.read && req_i.addr == rdm_pkg::MODE0_OFFSET && !wr_mode0)
      |=> rvalid_o && rdata_o[5:0] == mode0_core_buck_voltage;
  endproperty
  a_read_mode0: assert property (p_read_mode0) else $error("mode0 readback wrong");

  property p_bleed_core;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (reg_enable_i.core_buck || discharge[3]) |=> !bleed_on_o.core_buck;
  endproperty
  a_bleed_core: assert property (p_bleed_core) else $error("core bleed on wrongly");

  property p_bleed_sys;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!reg_enable_i.system_buck && !discharge[2]) |=> bleed_on_o.system_buck;
  endproperty
  a_bleed_sys: assert property (p_bleed_sys) else $error("system bleed missing");

  property p_bleed_ldo;
    @(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |=> bleed_on_o.aon_ldo == $past(!reg_enable_i.aon_ldo && !discharge[1]);
  endproperty
  a_bleed_ldo: assert property (p_bleed_ldo) else $error("aon bleed wrong");

  property p_ship;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_mode0 && req_i.wdata[7]) |=> ##1 ship_mode_o;
  endproperty
  a_ship: assert property (p_ship) else $error("ship mode not set");

  property p_pin_src;
    @(posedge mclk_i) disable iff (!rst_n_i)
    mode0_pin_mode_source |=> mode_sel_o == $past({mode_select_pin_b_i, mode_select_pin_a_i});
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin mode not used");

  property p_reg_src;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !mode0_pin_mode_source |=> mode_sel_o == $past({mode_reg_bit_b_i, mode_reg_bit_a_i});
  endproperty
  a_reg_src: assert property (p_reg_src) else $error("register mode not used");

  property p_nv_reset;
    @(posedge mclk_i)
    !rst_n_i |=> mode0_pin_mode_source == $past(nv_pin_source_i)
      && mode0_core_buck_voltage == $past(nv_core_volt_i) && !ship_en;
  endproperty
  a_nv_reset: assert property (p_nv_reset) else $error("reset defaults wrong");

  property p_fixed_mv;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode0_core_buck_voltage == 6'h3f) |=> core_buck_mv_o == 12'h708;
  endproperty
  a_fixed_mv: assert property (p_fixed_mv) else $error("fixed 1.8 V not chosen");

  property p_sat_mv;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode0_core_buck_voltage > 6'h28 && mode0_core_buck_voltage < 6'h3f)
      |=> core_buck_mv_o == 12'h5dc;
  endproperty
  a_sat_mv: assert property (p_sat_mv) else $error("saturation wrong");

  property p_reset_disch;
    @(posedge mclk_i)
    !rst_n_i |=> discharge == 8'h00 && !rvalid_o && rdata_o == 8'h00;
  endproperty
  a_reset_disch: assert property (p_reset_disch) else $error("discharge reset wrong");

  property p_reset_out;
    @(posedge mclk_i)
    !rst_n_i |=> bleed_on_o == 4'h0 && !ship_mode_o && mode_sel_o == 2'h0
      && core_buck_code_o == 6'h14 && core_buck_mv_o == 12'h3e8;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output reset wrong");

  property p_read_disch;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (req_i.read && req_i.addr == rdm_pkg::DISCHARGE_OFFSET && !wr_disch)
      |=> rvalid_o && rdata_o == discharge;
  endproperty
  a_read_disch: assert property (p_read_disch) else $error("discharge readback wrong");

  property p_read_unmapped;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (req_i.read && req_i.addr != rdm_pkg::DISCHARGE_OFFSET
      && req_i.addr != rdm_pkg::MODE0_OFFSET) |=> rvalid_o && rdata_o == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("bad unmapped read");

  property p_rvalid_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !req_i.read |=> !rvalid_o;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("rvalid without read");

  property p_rdata_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !req_i.read |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_mode0_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_mode0 |=> {ship_en, mode0_pin_mode_source, mode0_core_buck_voltage}
      == $past(req_i.wdata);
  endproperty
  a_mode0_write: assert property (p_mode0_write) else $error("mode0 write lost");

  property p_code_out;
    @(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |=> core_buck_code_o == $past(mode0_core_buck_voltage);
  endproperty
  a_code_out: assert property (p_code_out) else $error("code output wrong");

  property p_linear_mv;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode0_core_buck_voltage <= 6'h28)
      |=> core_buck_mv_o == 12'h1f4 + 12'h019 * 12'($past(mode0_core_buck_voltage));
  endproperty
  a_linear_mv: assert property (p_linear_mv) else $error("linear step wrong");

  property p_bleed_core_on;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!reg_enable_i.core_buck && !discharge[3]) |=> bleed_on_o.core_buck;
  endproperty
  a_bleed_core_on: assert property (p_bleed_core_on) else $error("core bleed off");

  property p_bleed_sys_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (reg_enable_i.system_buck || discharge[2]) |=> !bleed_on_o.system_buck;
  endproperty
  a_bleed_sys_off: assert property (p_bleed_sys_off) else $error("system bleed on");

  property p_bleed_sldo;
    @(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |=> bleed_on_o.system_ldo == $past(!reg_enable_i.system_ldo && !discharge[0]);
  endproperty
  a_bleed_sldo: assert property (p_bleed_sldo) else $error("system ldo bleed wrong");

  property p_ship_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_mode0 && !req_i.wdata[7]) |=> ##1 !ship_mode_o;
  endproperty
  a_ship_off: assert property (p_ship_off) else $error("ship mode not cleared");

  c_mode0_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i) wr_mode0);
  c_bleed: cover property (@(posedge mclk_i) disable iff (!rst_n_i) bleed_on_o.core_buck);
  c_pin: cover property (@(posedge mclk_i) disable iff (!rst_n_i) mode0_pin_mode_source);
  c_ship: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ship_mode_o);
  c_fixed: cover property (@(posedge mclk_i) disable iff (!rst_n_i) core_buck_mv_o == 12'h708);
endmodule // rdm_regs
`default_nettype wire

// file: test/rdm_host.sv
// host-side register access model for the bank
`timescale 1ns/1ps
`default_nettype none
module rdm_host (
  // clock
  input wire logic mclk_i,
  // answer from the bank
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  // request to the bank
  output rdm_pkg::rdm_req_t req_o
);
  initial req_o = '0;
  // strobe stays up between calls so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req_o <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
  endtask
  // released fields flip so stale values are never mistaken for live ones
  task automatic idle();
    @(negedge mclk_i);
    req_o <= '{write: 1'b0, read: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk_i);
    req_o <= '{write: 1'b0, read: 1'b1, addr: a, wdata: ~req_o.wdata};
    @(negedge mclk_i);
    d = rdata_i;
    v = rvalid_i;
    req_o <= '{write: 1'b0, read: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
  endtask
endmodule // rdm_host
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the discharge and mode-0 register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic nv_src = 1'b0;
  logic [5:0] nv_code = 6'h00;
  rdm_pkg::rdm_req_t req;
  rdm_pkg::rdm_reg4_t en = '0;
  rdm_pkg::rdm_reg4_t bleed;
  logic [3:0] pins = 4'h0;
  logic [7:0] rdata, d, disc, m0;
  logic rvalid, v, ship;
  logic [1:0] msel;
  logic [5:0] code;
  logic [11:0] mv;
  logic [31:0] seed = 32'hd453be02;
  logic [31:0] r;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  // rule model: register images as integers, reads queued against them
  int model_disc = 0;
  int model_m0 = 0;
  int exp_q[$];
  logic [7:0] last_rd = 8'h00;
  always #25 mclk_i = ~mclk_i;
  rdm_regs rdm_regs_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .nv_pin_source_i(nv_src), .nv_core_volt_i(nv_code), .reg_enable_i(en),
    .mode_select_pin_a_i(pins[0]), .mode_select_pin_b_i(pins[1]), .mode_reg_bit_a_i(pins[2]),
    .mode_reg_bit_b_i(pins[3]), .bleed_on_o(bleed), .ship_mode_o(ship), .mode_sel_o(msel),
    .core_buck_code_o(code), .core_buck_mv_o(mv));
  rdm_host rdm_host_inst (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_mv(int c);
    if (c == 63)
      return 1800;
    if (c <= 40)
      return 500 + 25 * c;
    return 1500;
  endfunction
  task automatic chk(string name, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] data);
    rdm_host_inst.wr(a, data);
    if (a == 8'h21)
      model_disc = int'(data);
    else if (a == 8'h22)
      model_m0 = int'(data);
  endtask
  task automatic read_reg(input logic [7:0] a, input string name);
    int e;
    e = (a == 8'h21) ? model_disc : ((a == 8'h22) ? model_m0 : 0);
    exp_q.push_back(256 + e);
    rdm_host_inst.rd(a, d, v);
    last_rd = d;
    chk(name, {3'h0, v, d}, 12'(exp_q.pop_front()));
  endtask
  // run needs about 1600 cycles
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    r = rnd();
    nv_src = r[6];
    nv_code = r[5:0];
    // second pass resets mid-run with the other nonvolatile straps
    for (int k = 0; k < 2; k++)
    begin
      rst_n_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      chk("reset code", 12'(code), 12'h014);
      chk("reset mv", mv, 12'h3e8);
      chk("reset bleed", {8'h00, bleed}, 12'h000);
      chk("reset read port", {3'h0, rvalid, rdata}, 12'h000);
      rst_n_i = 1'b1;
      model_disc = 0;
      model_m0 = int'({1'b0, nv_src, nv_code});
      repeat (2) @(negedge mclk_i);
      read_reg(8'h21, "discharge reset");
      read_reg(8'h22, "mode0 reset");
      chk("nv code out", 12'(code), 12'(nv_code));
      for (int i = 0; i < 64; i++)
      begin
        r = rnd();
        disc = r[7:0];
        m0 = {r[15:14], 6'(i)};
        write_reg(8'h21, disc);
        write_reg(8'h22, m0);
        write_reg(8'h23, r[31:24]);
        en = r[19:16];
        pins = r[23:20];
        rdm_host_inst.idle();
        repeat (2) @(negedge mclk_i);
        chk("bleed", {8'h00, bleed}, {8'h00, ~(en | disc[3:0])});
        chk("ship", 12'(ship), 12'(m0[7]));
        chk("mode sel", 12'(msel), 12'(m0[6] ? pins[1:0] : pins[3:2]));
        chk("code", 12'(code), 12'(i));
        chk("mv", mv, 12'(exp_mv(i)));
        chk("rvalid idle", {11'h000, rvalid}, 12'h000);
        chk("rdata hold", {4'h0, rdata}, {4'h0, last_rd});
        read_reg(8'h21, "read 21");
        read_reg(8'h22, "read 22");
        read_reg(8'h23, "read unmapped");
      end
      nv_src = ~nv_src;
      nv_code = ~nv_code;
    end
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
